/* File: rtl/synth_port_consts.svh */
// constants for the serial control port: register bit positions, frame lengths,
// reset values, host timing and host register map; included by the device, host and bench files
`ifndef SYNTH_PORT_CONSTS_SVH
`define SYNTH_PORT_CONSTS_SVH

// control byte bit positions
`define C_SAMPLE     7
`define C_READ_A     6
`define C_READ_F     5
`define C_CHAN       4
`define C_OUT_A      3
`define C_OUT_B      2
`define C_OUT_C      1
// reference configuration bit positions
`define R_POL        23
`define R_BAND       22
`define R_ACCEPT     21
`define R_OUT_D      20
`define R_STANDBY    19
`define R_COUNT_GO   18
`define R_DIV_MSB    13
// reset values
`define C_RESET      8'h00
`define N_RESET      16'h0000
`define R_RESET      24'h000000
// frame lengths in serial clocks
`define LEN_C        6'h08
`define LEN_N        6'h10
`define LEN_R        6'h18
`define LEN_MAX      6'h21
// acceptor: stable reference edges per half period of an accepted signal
`define ACCEPT_EDGES 3'h4
// host serial clock half period
`define SCLK_HALF_NS 800
`define CORE_CLK_NS  100
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
// host register map (byte addresses)
`define ADDR_CTRL    4'h0
`define ADDR_TXD     4'h4
`define ADDR_RXD     4'h8
`define ADDR_STAT    4'hc
`define CTRL_GO      8
`define AXI_OKAY     2'h0
`define AXI_SLVERR   2'h2

`endif

/* File: rtl/synth_port_pkg.sv */
// types shared by both ends of the serial control port
// assumes the constants header sits beside it
package synth_port_pkg;

	// device framing states
	typedef enum logic [2:0] {
		DESYNC = 3'h1,
		IDLE   = 3'h2,
		ACTIVE = 3'h4
	} dev_state_t;

	// host sequencer states
	typedef enum logic [4:0] {
		H_IDLE = 5'h01,
		H_LEAD = 5'h02,
		H_LOW  = 5'h04,
		H_HIGH = 5'h08,
		H_TAIL = 5'h10
	} host_state_t;

endpackage

/* File: rtl/synth_serial_if.sv */
// four-wire serial link between the host controller and the synthesizer port
// assumes a pull-down on the data output wire while the device releases it
`timescale 1ns/1ps
interface synth_serial_if;
	logic sclk;
	logic sdi;
	logic sel_n;
	logic sdo;
	logic sdo_oe;
	logic sdo_line;

	// resolved level of the three-state data output
	assign sdo_line = sdo_oe ? sdo : 1'h0;

	modport device (input sclk, input sdi, input sel_n, output sdo, output sdo_oe);
	modport host   (input sdo_line, output sclk, output sdi, output sel_n);
endinterface

/* File: rtl/synth_port_device.sv */
// device end of the serial control port: framing, write registers, read-back,
// general-purpose pins, converter channel select, reference and IF steering
// assumes all pins are sampled on CORE_CLK, which runs well above the serial clock
`timescale 1ns/1ps
`include "synth_port_consts.svh"

// What this block does
// - host moves select only with clock low
// - resync when select high, clock low
// - read-back out on falling clock, MSB first
// - status read in 8, 9 or 16 clocks
// - count read spans 24 clocks
// - read select bits set before reading
// - comparator input level in status
// - CMOS input in status and count
// - three outputs follow control byte bits
// - fourth output follows reference configuration bit
// - all four outputs low after power-up
// - control bit selects converter channel
// - reference divider decrements per rising oscillator edge
// - standby pulls oscillator, low IF low
// - upper band releases buffered reference output
// - low band feeds counter from low IF
// - acceptor passes IF below oscillator over eight
// - 8/16/24 clocks load register on deselect
// - data in MSB first, sampled rising
// - select high blocks shifting, releases output
module synth_port_device
	import synth_port_pkg::*;
(
	input  logic                  CORE_CLK,
	input  logic                  SYS_RST,
	synth_serial_if.device        PORT,
	input  logic                  COMPARATOR_IN,
	input  logic                  CMOS_IN,
	input  logic [5:0]            ADC_RESULT,
	input  logic                  ADC_DONE,
	input  logic [21:0]           COUNT_VALUE,
	input  logic                  COUNT_DONE,
	input  logic                  REF_OSC_IN,
	input  logic                  LOW_IF_IN,
	input  logic                  HIGH_IF_IN,
	output logic                  OUT_A_O,
	output logic                  OUT_A_OE,
	output logic                  OUT_B,
	output logic                  OUT_C,
	output logic                  OUT_D,
	output logic                  ADC_START,
	output logic                  ADC_CHAN_SEL,
	output logic                  COUNT_START,
	output logic                  COUNT_INPUT,
	output logic                  REF_OSC_PULLDOWN,
	output logic                  LOW_IF_PULLDOWN,
	output logic                  BUFFERED_REFERENCE_OUTPUT_O,
	output logic                  BUFFERED_REFERENCE_OUTPUT_OE,
	output logic                  REF_TICK,
	output logic                  DETECT_POLARITY,
	output logic                  BAND_SELECT,
	output logic [15:0]           N_DIVIDE
);

	typedef struct packed {
		dev_state_t  st;
		logic [2:0]  sclk_sy;     // [0] first stage, [1] second, [2] previous
		logic [2:0]  sel_sy;
		logic [1:0]  sdi_sy;
		logic [1:0]  cmp_sy;
		logic [1:0]  cmos_sy;
		logic [2:0]  osc_sy;
		logic [1:0]  lif_sy;
		logic [1:0]  hif_sy;
		logic [5:0]  bits;
		logic [23:0] shin;
		logic [24:0] shout;
		logic [7:0]  c_reg;
		logic [15:0] n_reg;
		logic [23:0] r_reg;
		logic [13:0] rdiv;
		logic        ref_tick;
		logic [2:0]  acc;
		logic        lif_ok;
		logic        count_in;
		logic        ref_oe;
		logic        sdo;
		logic        sdo_oe;
	} dev_regs_t;

	dev_regs_t cur;
	dev_regs_t nxt;

	logic sclk_s;
	logic sel_s;
	logic sel_edge;
	logic sel_fall;
	logic sel_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic osc_rise;
	logic standby;
	logic band;

	// edges taken from second stage only
	assign sclk_s    = cur.sclk_sy[1];
	assign sel_s     = cur.sel_sy[1];
	assign sel_edge  = cur.sel_sy[1] ^ cur.sel_sy[2];
	assign sel_fall  = sel_edge & ~sel_s;
	assign sel_rise  = sel_edge & sel_s;
	assign sclk_rise = cur.sclk_sy[1] & ~cur.sclk_sy[2];
	assign sclk_fall = ~cur.sclk_sy[1] & cur.sclk_sy[2];
	assign osc_rise  = cur.osc_sy[1] & ~cur.osc_sy[2];
	assign standby   = cur.r_reg[`R_STANDBY];
	assign band      = cur.r_reg[`R_BAND];

	// next-state logic of the whole port
	always_comb begin
		nxt = cur;
		nxt.sclk_sy = {cur.sclk_sy[1:0], PORT.sclk};
		nxt.sel_sy  = {cur.sel_sy[1:0], PORT.sel_n};
		nxt.sdi_sy  = {cur.sdi_sy[0], PORT.sdi};
		nxt.cmp_sy  = {cur.cmp_sy[0], COMPARATOR_IN};
		nxt.cmos_sy = {cur.cmos_sy[0], CMOS_IN};
		nxt.lif_sy  = {cur.lif_sy[0], LOW_IF_IN & ~standby};
		nxt.hif_sy  = {cur.hif_sy[0], HIGH_IF_IN};
		nxt.osc_sy  = {cur.osc_sy[1:0], REF_OSC_IN & ~standby};

		case (cur.st)
			DESYNC: begin
				// resync on select high, clock low
				if (sel_s && !sclk_s) begin
					nxt.st = IDLE;
				end
			end
			IDLE: begin
				nxt.bits = 6'h00;
				// select edge with clock high loses sync
				if (sel_edge && sclk_s) begin
					nxt.st = DESYNC;
				end else if (sel_fall) begin
					nxt.st = ACTIVE;
					// read select bits pick the source
					if (cur.c_reg[`C_READ_F]) begin
						nxt.shout = {COUNT_DONE, cur.cmos_sy[1], COUNT_VALUE, 1'h0};
					end else if (cur.c_reg[`C_READ_A]) begin
						// status word, ninth bit, then zeros
						nxt.shout = {ADC_DONE, ADC_RESULT, cur.cmp_sy[1], cur.cmos_sy[1],
							16'h0000};
					end else begin
						nxt.shout = 25'h0000000;
					end
				end
			end
			ACTIVE: begin
				if (sel_edge && sclk_s) begin
					nxt.st = DESYNC;
				end else if (sel_rise) begin
					nxt.st = IDLE;
					case (cur.bits)
						`LEN_C:  nxt.c_reg = cur.shin[7:0];
						`LEN_N:  nxt.n_reg = cur.shin[15:0];
						`LEN_R:  nxt.r_reg = cur.shin;
						default: nxt.c_reg = cur.c_reg;
					endcase
				end else begin
					if (sclk_rise) begin
						nxt.shin = {cur.shin[22:0], cur.sdi_sy[1]};
						if (cur.bits != `LEN_MAX) begin
							nxt.bits = cur.bits + 6'h01;
						end
					end
					if (sclk_fall) begin
						nxt.shout = {cur.shout[23:0], 1'h0};
					end
				end
			end
			default: nxt.st = DESYNC;
		endcase

		nxt.sdo_oe = (nxt.st == ACTIVE);
		nxt.sdo    = (nxt.st == ACTIVE) ? nxt.shout[24] : 1'h0;

		nxt.ref_tick = 1'h0;
		if (osc_rise) begin
			if (cur.rdiv <= 14'h0001) begin
				nxt.rdiv     = cur.r_reg[`R_DIV_MSB:0];
				nxt.ref_tick = 1'h1;
			end else begin
				nxt.rdiv = cur.rdiv - 14'h0001;
			end
		end

		// integrator needs stable level for set edges
		if (osc_rise) begin
			if (cur.lif_sy[1] == cur.lif_ok) begin
				nxt.acc = 3'h0;
			end else if (cur.acc == `ACCEPT_EDGES - 3'h1) begin
				nxt.acc    = 3'h0;
				nxt.lif_ok = cur.lif_sy[1];
			end else begin
				nxt.acc = cur.acc + 3'h1;
			end
		end

		if (band) begin
			nxt.count_in = cur.hif_sy[1];
		end else if (cur.r_reg[`R_ACCEPT]) begin
			nxt.count_in = cur.lif_ok;
		end else begin
			nxt.count_in = cur.lif_sy[1];
		end

		nxt.ref_oe = ~band & cur.osc_sy[1];
	end

	// state register
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			cur       <= '0;
			cur.st    <= DESYNC;
			cur.c_reg <= `C_RESET;
			cur.n_reg <= `N_RESET;
			cur.r_reg <= `R_RESET;
		end else begin
			cur <= nxt;
		end
	end

	assign PORT.sdo    = cur.sdo;
	assign PORT.sdo_oe = cur.sdo_oe;

	// reset clears bits, pins drive low
	assign OUT_A_O  = 1'h0;
	assign OUT_A_OE = ~cur.c_reg[`C_OUT_A];   // pull low unless bit set
	assign OUT_B    = cur.c_reg[`C_OUT_B];
	assign OUT_C    = cur.c_reg[`C_OUT_C];
	assign OUT_D    = cur.r_reg[`R_OUT_D];

	assign ADC_CHAN_SEL = cur.c_reg[`C_CHAN];
	assign ADC_START    = cur.c_reg[`C_SAMPLE];
	assign COUNT_START  = cur.r_reg[`R_COUNT_GO];
	assign COUNT_INPUT  = cur.count_in;

	assign REF_OSC_PULLDOWN = standby;
	assign LOW_IF_PULLDOWN  = standby;

	// open-drain high-side driver of the buffered reference
	assign BUFFERED_REFERENCE_OUTPUT_O  = 1'h1;
	assign BUFFERED_REFERENCE_OUTPUT_OE = cur.ref_oe;

	assign REF_TICK        = cur.ref_tick;
	assign DETECT_POLARITY = cur.r_reg[`R_POL];
	assign BAND_SELECT     = band;
	assign N_DIVIDE        = cur.n_reg;

endmodule

/* File: rtl/synth_port_host.sv */
// host end of the serial control port: AXI4-Lite register slave that runs frames
// assumes the device answers within a serial clock half period of CORE_CLK cycles
`timescale 1ns/1ps
`include "synth_port_consts.svh"

module synth_port_host
	import synth_port_pkg::*;
#(
	parameter logic [7:0] SCLK_HALF = 8'(`SCLK_HALF_CYC)
)(
	input  logic                  CORE_CLK,
	input  logic                  SYS_RST,
	synth_serial_if.host          PORT,
	input  logic [3:0]            AWADDR,
	input  logic                  AWVALID,
	output logic                  AWREADY,
	input  logic [31:0]           WDATA,
	input  logic [3:0]            WSTRB,
	input  logic                  WVALID,
	output logic                  WREADY,
	output logic [1:0]            BRESP,
	output logic                  BVALID,
	input  logic                  BREADY,
	input  logic [3:0]            ARADDR,
	input  logic                  ARVALID,
	output logic                  ARREADY,
	output logic [31:0]           RDATA,
	output logic [1:0]            RRESP,
	output logic                  RVALID,
	input  logic                  RREADY
);

	typedef struct packed {
		host_state_t st;
		logic [7:0]  div;
		logic [5:0]  left;
		logic [31:0] txd;
		logic [31:0] tx;
		logic [31:0] rx;
		logic        done;
		logic        sclk;
		logic        sdi;
		logic        sel_n;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} host_regs_t;

	host_regs_t cur;
	host_regs_t nxt;
	logic       wr_go;
	logic       rd_go;
	logic       half_end;
	logic [5:0] len;

	// write taken when address and data are both offered
	assign AWREADY  = AWVALID & WVALID & ~cur.bvalid;
	assign WREADY   = AWREADY;
	assign wr_go    = AWREADY;
	assign ARREADY  = ~cur.rvalid;
	assign rd_go    = ARVALID & ~cur.rvalid;
	assign half_end = (cur.div == 8'h00);
	assign len      = (WDATA[5:0] > 6'h20) ? 6'h20 : WDATA[5:0];

	// register slave and frame sequencer
	always_comb begin
		nxt = cur;
		if (cur.bvalid && BREADY) begin
			nxt.bvalid = 1'h0;
		end
		if (cur.rvalid && RREADY) begin
			nxt.rvalid = 1'h0;
		end
		if (!half_end) begin
			nxt.div = cur.div - 8'h01;
		end

		// bus write: frame start or transmit data
		if (wr_go) begin
			nxt.bvalid = 1'h1;
			nxt.bresp  = `AXI_OKAY;
			case (AWADDR)
				`ADDR_CTRL: begin
					if (WSTRB[1] && WDATA[`CTRL_GO] && cur.st == H_IDLE && len != 6'h00) begin
						nxt.st    = H_LEAD;
						nxt.left  = len;
						nxt.tx    = cur.txd << (6'h20 - len);
						nxt.rx    = 32'h00000000;
						nxt.done  = 1'h0;
						nxt.sel_n = 1'h0;   // select falls with clock low
						nxt.div   = SCLK_HALF;
					end
				end
				`ADDR_TXD: begin
					for (int i = 0; i < 4; i++) begin
						if (WSTRB[i]) begin
							nxt.txd[i*8 +: 8] = WDATA[i*8 +: 8];
						end
					end
				end
				`ADDR_RXD, `ADDR_STAT: nxt.bresp = `AXI_OKAY;
				default: nxt.bresp = `AXI_SLVERR;
			endcase
		end

		// bus read
		if (rd_go) begin
			nxt.rvalid = 1'h1;
			nxt.rresp  = `AXI_OKAY;
			case (ARADDR)
				`ADDR_CTRL: nxt.rdata = {26'h0000000, cur.left};
				`ADDR_TXD:  nxt.rdata = cur.txd;
				`ADDR_RXD:  nxt.rdata = cur.rx;
				`ADDR_STAT: nxt.rdata = {30'h00000000, cur.done, cur.st != H_IDLE};
				default: begin
					nxt.rdata = 32'h00000000;
					nxt.rresp = `AXI_SLVERR;
				end
			endcase
		end

		case (cur.st)
			// a go taken this cycle must keep select low
			H_IDLE: nxt.sel_n = (nxt.st == H_IDLE);
			H_LEAD: begin
				if (half_end) begin
					nxt.st  = H_LOW;
					nxt.sdi = cur.tx[31];   // MSB first
					nxt.div = SCLK_HALF;
				end
			end
			H_LOW: begin
				if (half_end) begin
					nxt.div = SCLK_HALF;
					if (cur.left == 6'h00) begin
						nxt.st    = H_TAIL;
						nxt.sel_n = 1'h1;
					end else begin
						nxt.st   = H_HIGH;
						nxt.sclk = 1'h1;
						nxt.rx   = {cur.rx[30:0], PORT.sdo_line};
					end
				end
			end
			H_HIGH: begin
				if (half_end) begin
					nxt.st   = H_LOW;
					nxt.sclk = 1'h0;
					nxt.tx   = {cur.tx[30:0], 1'h0};
					nxt.sdi  = cur.tx[30];
					nxt.left = cur.left - 6'h01;
					nxt.div  = SCLK_HALF;
				end
			end
			H_TAIL: begin
				if (half_end) begin
					nxt.st   = H_IDLE;
					nxt.done = 1'h1;
					nxt.sdi  = 1'h0;
				end
			end
			default: nxt.st = H_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			cur       <= '0;
			cur.st    <= H_IDLE;
			cur.sel_n <= 1'h1;
		end else begin
			cur <= nxt;
		end
	end

	assign PORT.sclk  = cur.sclk;
	assign PORT.sdi   = cur.sdi;
	assign PORT.sel_n = cur.sel_n;
	assign BVALID     = cur.bvalid;
	assign BRESP      = cur.bresp;
	assign RVALID     = cur.rvalid;
	assign RDATA      = cur.rdata;
	assign RRESP      = cur.rresp;

endmodule

/* File: verification/synth_port_monitor.sv */
// link checker: framing, clock spacing and data-out timing on the serial wires
// assumes it sits beside the link interface and sees the core clock and reset
`timescale 1ns/1ps

module synth_port_monitor (
	input  wire logic CORE_CLK,
	input  wire logic SYS_RST,
	input  wire logic sclk,
	input  wire logic sdi,
	input  wire logic sel_n,
	input  wire logic sdo,
	input  wire logic sdo_oe
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);

	// select moves only while the serial clock rests low
	chk_sel_clk_low: assert property ($changed(sel_n) |-> !sclk && !$past(sclk))
		else $error("select moved with serial clock high");
	chk_idle_no_clock: assert property (sel_n |-> !sclk)
		else $error("serial clock high while deselected");
	// data out released and kept off while deselected
	chk_oe_release: assert property ($rose(sel_n) |-> ##[0:4] !sdo_oe)
		else $error("data out still driven after deselect");
	chk_oe_off_idle: assert property (sel_n [*5] |-> !sdo_oe)
		else $error("data out driven while deselected");
	chk_oe_after_sel: assert property ($rose(sdo_oe) |-> !sel_n && !$past(sel_n, 2))
		else $error("data out driven without a selected frame");
	// data out moves only in the low phase after a falling clock
	chk_dout_on_fall: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo)
		|-> !sclk && !$past(sclk, 3))
		else $error("data out changed outside the falling phase");
	chk_dout_hold_high: assert property (sclk && $past(sclk) && sdo_oe && $past(sdo_oe)
		|-> $stable(sdo))
		else $error("data out moved during high clock");
	// data in held while the clock stays high
	chk_din_steady: assert property (sclk && $past(sclk) |-> $stable(sdi))
		else $error("data in moved while clock high");
	chk_clk_half: assert property ($changed(sclk) |=> $stable(sclk) [*8])
		else $error("serial clock half period too short");
endmodule

/* File: verification/serial_port_gpio_and_input_steering_tb.sv */
// bench: host and device ends joined by the link, driven from the bus side
// assumes the rtl files and the link checker are compiled before it
`timescale 1ns/1ps
`include "synth_port_consts.svh"
`define CHECK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_fail++; \
	$display("mismatch %s expected %h seen %h", nm, ex, gt); end end

module serial_port_gpio_and_input_steering_tb import synth_port_pkg::*;;
	logic        CORE_CLK = 1'h0;
	logic        SYS_RST = 1'h1;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	logic [3:0]  awaddr = 4'h0;
	logic [3:0]  araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] rx;
	logic [1:0]  bresp, rresp;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        cmp_in = 1'h0, cmos_in = 1'h0, adc_done = 1'h0, count_done = 1'h0;
	logic        ref_osc = 1'h0, low_if = 1'h0, high_if = 1'h0;
	logic [5:0]  adc_result = 6'h0;
	logic [21:0] count_value = 22'h0;
	logic        out_a_oe, out_b, out_c, out_d, adc_start, adc_chan, count_start, count_input;
	logic        ref_pd, low_pd, bref_oe, ref_tick, det_pol, band;
	logic [15:0] n_div;

	synth_serial_if link ();

	synth_port_host u_synth_port_host (
		.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PORT(link),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf),
		.WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready)
	);

	synth_port_device u_synth_port_device (
		.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PORT(link),
		.COMPARATOR_IN(cmp_in), .CMOS_IN(cmos_in), .ADC_RESULT(adc_result),
		.ADC_DONE(adc_done), .COUNT_VALUE(count_value), .COUNT_DONE(count_done),
		.REF_OSC_IN(ref_osc), .LOW_IF_IN(low_if), .HIGH_IF_IN(high_if),
		.OUT_A_O(), .OUT_A_OE(out_a_oe), .OUT_B(out_b), .OUT_C(out_c), .OUT_D(out_d),
		.ADC_START(adc_start), .ADC_CHAN_SEL(adc_chan), .COUNT_START(count_start),
		.COUNT_INPUT(count_input), .REF_OSC_PULLDOWN(ref_pd), .LOW_IF_PULLDOWN(low_pd),
		.BUFFERED_REFERENCE_OUTPUT_O(), .BUFFERED_REFERENCE_OUTPUT_OE(bref_oe),
		.REF_TICK(ref_tick), .DETECT_POLARITY(det_pol), .BAND_SELECT(band), .N_DIVIDE(n_div)
	);

	synth_port_monitor u_synth_port_monitor (
		.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .sclk(link.sclk), .sdi(link.sdi),
		.sel_n(link.sel_n), .sdo(link.sdo), .sdo_oe(link.sdo_oe)
	);

	// core clock and hang guard
	always #50 CORE_CLK = ~CORE_CLK;
	always @(posedge CORE_CLK) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// bus write: address and data offered together, each released when taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok   = 1'h0;
		w_ok    = 1'h0;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge CORE_CLK);
			if (!aw_ok && awready) begin
				aw_ok = 1'h1;
				awvalid <= 1'h0;
			end
			if (!w_ok && wready) begin
				w_ok = 1'h1;
				wvalid <= 1'h0;
			end
		end
		bready  <= 1'h1;
		do @(posedge CORE_CLK); while (!bvalid);
		bready  <= 1'h0;
		`CHECK("bresp", `AXI_OKAY, bresp)
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
		araddr  <= a;
		arvalid <= 1'h1;
		do @(posedge CORE_CLK); while (!arready);
		arvalid <= 1'h0;
		rready  <= 1'h1;
		do @(posedge CORE_CLK); while (!rvalid);
		d = rdata;
		rready  <= 1'h0;
		`CHECK("rresp", `AXI_OKAY, rresp)
	endtask

	// one serial frame of len clocks, returning the captured bits
	task automatic frame(input logic [5:0] len, input logic [31:0] tx, output logic [31:0] d);
		logic [31:0] s;
		s = 32'h0;
		axi_wr(`ADDR_TXD, tx);
		axi_wr(`ADDR_CTRL, 32'h100 | 32'(len));
		while (s[1] !== 1'h1) axi_rd(`ADDR_STAT, s);
		axi_rd(`ADDR_RXD, d);
	endtask

	task automatic t_ctrl();
		logic [7:0] c;
		for (int i = 0; i < 2; i++) begin
			c = i ? 8'h04 : 8'h9a;
			frame(`LEN_C, 32'(c), rx);
			`CHECK("out_a_oe", ~c[3], out_a_oe)
			`CHECK("out_bc", c[2:1], {out_b, out_c})
			`CHECK("adc_chan", c[4], adc_chan)
			`CHECK("adc_start", c[7], adc_start)
		end
		$display("end of control test");
	endtask

	task automatic t_nreg();
		frame(`LEN_N, 32'ha5c3, rx);
		`CHECK("n_divide", 16'ha5c3, n_div)
		frame(6'h0c, 32'h0fff, rx);
		`CHECK("n_divide kept", 16'ha5c3, n_div)
		$display("end of divider test");
	endtask

	// reference word fields, band steering and counter input choice
	task automatic t_rreg();
		logic [23:0] r;
		ref_osc <= 1'h1;
		for (int i = 0; i < 2; i++) begin
			r = i ? 24'h040003 : 24'hd80003;
			frame(`LEN_R, 32'(r), rx);
			`CHECK("out_d", r[20], out_d)
			`CHECK("pol_band", r[23:22], {det_pol, band})
			`CHECK("standby", {2{r[19]}}, {ref_pd, low_pd})
			`CHECK("count_start", r[18], count_start)
			`CHECK("ref_out_oe", ~r[22], bref_oe)
			for (int b = 0; b < 2; b++) begin
				high_if <= b[0];
				low_if  <= ~b[0];
				repeat (6) @(posedge CORE_CLK);
				`CHECK("count_input", r[22] ~^ b[0], count_input)
			end
		end
		$display("end of reference test");
	endtask

	task automatic t_tick();
		int n;
		n = 0;
		frame(`LEN_R, 32'h000003, rx);
		for (int i = 0; i < 240; i++) begin
			@(posedge CORE_CLK);
			ref_osc <= i[2];
			n += int'(ref_tick);
		end
		`CHECK("ticks", 1'h1, n >= 9 && n <= 11)
		$display("end of tick test");
	endtask

	// fast low-band input is rejected, slow one passes
	task automatic t_accept();
		int   n;
		logic last;
		frame(`LEN_R, 32'h200003, rx);
		for (int k = 0; k < 2; k++) begin
			n = 0;
			last = count_input;
			for (int i = 0; i < 256; i++) begin
				@(posedge CORE_CLK);
				ref_osc <= i[1];
				low_if  <= k ? i[6] : i[2];
				n += int'(count_input !== last);
				last = count_input;
			end
			`CHECK("acceptor", 1'h1, k ? n >= 2 : n == 0)
		end
		$display("end of acceptor test");
	endtask

	task automatic t_status();
		logic [15:0] full;
		logic [5:0]  l;
		adc_result <= 6'h2d;
		adc_done   <= 1'h1;
		frame(`LEN_C, 32'h40, rx);
		for (int i = 0; i < 3; i++) begin
			cmp_in  <= i[0];
			cmos_in <= ~i[0];
			l = (i == 0) ? 6'h08 : (i == 1) ? 6'h09 : 6'h10;
			full = {1'h1, 6'h2d, i[0], ~i[0], 7'h0};
			frame(l, 32'h40, rx);
			`CHECK("status", 32'(full >> (16 - l)), rx)
		end
		frame(`LEN_C, 32'h0, rx);
		frame(`LEN_C, 32'h0, rx);
		`CHECK("no select", 32'h0, rx)
		$display("end of status test");
	endtask

	task automatic t_count();
		count_value <= 22'h2a5f3c;
		count_done  <= 1'h0;
		cmos_in     <= 1'h1;
		frame(`LEN_C, 32'h60, rx);
		frame(`LEN_R, 32'h000003, rx);
		`CHECK("count", {8'h0, 1'h0, 1'h1, 22'h2a5f3c}, rx)
		$display("end of count test");
	endtask

	// mid-run reset clears the outputs and the port resyncs
	task automatic t_reset();
		SYS_RST <= 1'h1;
		repeat (10) @(posedge CORE_CLK);
		SYS_RST <= 1'h0;
		@(posedge CORE_CLK);
		`CHECK("reset outputs", 5'h10, {out_a_oe, out_b, out_c, out_d, band})
		frame(`LEN_N, 32'h1234, rx);
		`CHECK("resync", 16'h1234, n_div)
		$display("end of reset test");
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge CORE_CLK);
		SYS_RST <= 1'h0;
		@(posedge CORE_CLK);
		`CHECK("outputs", 4'h8, {out_a_oe, out_b, out_c, out_d})
		t_ctrl();
		t_nreg();
		t_rreg();
		t_tick();
		t_accept();
		t_status();
		t_count();
		t_reset();
		give_verdict();
	end
endmodule
